/* tfirq_core_model.sv */
/*
 * core stand-in: instruction boundaries, halt and return pulses.
 * assumes tfirq_ctrl on the same ref_clk; the bench pulses step, halt and return requests for one cycle.
 */
module tfirq_core_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// requests from the bench
	input wire logic run_en,
	input wire logic slow,
	input wire logic step_req,
	input wire logic halt_req,
	input wire logic ret_req,
	// handshake towards the block
	output logic instr_done,
	output logic halt_instr,
	output logic handler_return_instruction
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase_q; // position inside a three-clock instruction
	// ----------------------------------------
	// instruction pacing
	// ----------------------------------------
	// slow mode makes every run_en instruction three clocks long (a step_req ends one at once), so a request
	// that lands mid-instruction has to wait for the boundary
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q <= 2'h0;
			instr_done <= 1'b0;
			halt_instr <= 1'b0;
			handler_return_instruction <= 1'b0;
		end
		else
		begin
			phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
			instr_done <= step_req | (run_en & (!slow | phase_q == 2'h2));
			halt_instr <= halt_req;
			handler_return_instruction <= ret_req;
		end
	end
endmodule // tfirq_core_model

/* tfirq_ctrl.sv */
/*
 * timer event flags, external pin interrupts, entry/return sequencing and
 * sleep control bits for a small 8-bit controller.
 * assumes the timers, core and pins share ref_clk; the core pulses
 * instruction boundaries, halt and return and takes vectors when told.
 */
// Decided for this implementation: the plain strobed port.
`include "tfirq_regs.svh"
module tfirq_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// timer events, one-cycle pulses, plus the pwm mode level and the count and compare values
	input wire logic wide_ovf_evt,
	input wire logic wide_pwm_mode,
	input wire logic wide_leave_zero_evt,
	input wire logic [15:0] wide_count,
	input wire logic [15:0] compare_value,
	input wire logic capture_evt,
	input wire logic narrow_ovf_evt,
	// external pins, read regardless of direction
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	// core handshake
	input wire logic instr_done,
	input wire logic halt_instr,
	input wire logic handler_return_instruction,
	output logic irq_take,
	output logic [2:0] irq_vector,
	output logic vector_jump,
	output logic sp_dec2,
	output logic sp_inc2,
	output logic sleep_idle,
	output logic sleep_power_down
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] flags_q, flags_d; // timer event flags
	logic [7:0] tmask_q; // timer mask register
	logic [7:0] emask_q; // external mask register
	logic [7:0] eflag_q, eflag_d; // external event flags
	logic [7:0] ctl_q; // sleep and sense control
	logic gie_q, gie_d; // global interrupt enable
	logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q; // pin samplers
	logic [2:0] cnt_q, cnt_d; // sequencer counter
	logic [2:0] vec_q, vec_d; // vector being served
	tfirq_pkg::tfirq_state_type st_q, st_d; // sequencer state
	logic [7:0] rdata_d;

	// ----------------------------------------
	// decode helper
	// ----------------------------------------
	// sense decode, used for both pins
	function automatic logic sense_hit(input logic [1:0] sel,
		input logic cur, input logic prev);
		case (tfirq_pkg::tfirq_sense_type'(sel))
			tfirq_pkg::TFIRQ_ANY: sense_hit = cur ^ prev;
			tfirq_pkg::TFIRQ_FALL: sense_hit = prev & ~cur;
			tfirq_pkg::TFIRQ_RISE: sense_hit = cur & ~prev;
			default: sense_hit = 1'b0; // level mode sets no flag
		endcase
	endfunction

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	// second stage and third stage feed detection; first is sync only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_q <= 2'h3;
			pin_s2_q <= 2'h3;
			pin_s3_q <= 2'h3;
		end
		else
		begin
			pin_s1_q <= {ext_irq_pin_b, ext_irq_pin_a}; // RQ21 RQ10
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// edge hits per pin (index 1 = b, 0 = a)
	wire [1:0] edge_hit;
	wire [1:0] level_req;
	wire [1:0] ext_sel [2];
	assign ext_sel[0] = ctl_q[1:0]; // RQ19
	assign ext_sel[1] = ctl_q[3:2]; // RQ18
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			assign edge_hit[gi] = sense_hit(ext_sel[gi], pin_s2_q[gi],
				pin_s3_q[gi]);
			// no flag, request lasts while low
			assign level_req[gi] = (ext_sel[gi] == 2'h0) & ~pin_s2_q[gi]; // RQ11 RQ24
		end
	endgenerate

	// ----------------------------------------
	// request arbitration, lowest vector first
	// ----------------------------------------
	wire [1:0] ext_en = {emask_q[`TFIRQ_BIT_EXT_B], emask_q[`TFIRQ_BIT_EXT_A]};
	wire [1:0] ext_pend = ext_en & ({eflag_q[7], eflag_q[6]} | level_req); // RQ23
	wire [7:0] tpend = flags_q & tmask_q; // RQ25
	wire any_req = gie_q & ((|ext_pend) | (|tpend)); // RQ8
	wire [2:0] pick_vec = ext_pend[0] ? 3'h1 : ext_pend[1] ? 3'h2 :
		tpend[`TFIRQ_BIT_CAPTURE] ? 3'h3 : tpend[`TFIRQ_BIT_COMPARE] ? 3'h4 :
		tpend[`TFIRQ_BIT_WIDE_OVF] ? 3'h5 : 3'h6;
	// hand over only at an instruction boundary
	wire start_entry = (st_q == tfirq_pkg::TFIRQ_RUN) & any_req & instr_done; // RQ13
	wire vec_clear = (st_q == tfirq_pkg::TFIRQ_ENTRY) & (cnt_q == 3'h1);

	// ----------------------------------------
	// register write decode
	// ----------------------------------------
	wire wr_tflag = reg_wr & (reg_addr == `TFIRQ_OFS_TIMER_FLAGS);
	wire wr_eflag = reg_wr & (reg_addr == `TFIRQ_OFS_EXT_FLAGS);
	wire wr_ctl = reg_wr & (reg_addr == `TFIRQ_OFS_SLEEP_SENSE);
	wire wr_tmask = reg_wr & (reg_addr == `TFIRQ_OFS_TIMER_MASK);
	wire wr_emask = reg_wr & (reg_addr == `TFIRQ_OFS_EXT_MASK);
	wire wr_stat = reg_wr & (reg_addr == `TFIRQ_OFS_STATUS);

	// hardware set events in flag positions
	wire [7:0] tset;
	assign tset[`TFIRQ_BIT_WIDE_OVF] = wide_pwm_mode ? wide_leave_zero_evt // RQ2
		: wide_ovf_evt; // RQ1
	assign tset[`TFIRQ_BIT_COMPARE] = (wide_count == compare_value); // RQ3
	assign tset[`TFIRQ_BIT_CAPTURE] = capture_evt; // RQ4
	assign tset[`TFIRQ_BIT_NARROW_OVF] = narrow_ovf_evt; // RQ5
	assign {tset[5:4], tset[2], tset[0]} = 4'h0;
	wire [7:0] eset = {edge_hit[1], edge_hit[0], 6'h00};

	// vector number to flag position
	wire [7:0] tvec_clr = {vec_q == 3'h5, vec_q == 3'h4, 2'b00,
		vec_q == 3'h3, 1'b0, vec_q == 3'h6, 1'b0} & {8{vec_clear}};
	wire [7:0] evec_clr = {vec_q == 3'h2, vec_q == 3'h1, 6'h00} &
		{8{vec_clear}};
	wire [7:0] tclr = (wr_tflag ? reg_wdata : 8'h00) | tvec_clr; // RQ7 RQ6
	wire [7:0] eclr = (wr_eflag ? reg_wdata : 8'h00) | evec_clr;

	// set wins over clear, reserved forced low
	assign flags_d = ((flags_q & ~tclr) | tset) & `TFIRQ_TIMER_MASK_BITS; // RQ26 RQ9
	assign eflag_d = ((eflag_q & ~eclr) | eset) & `TFIRQ_EXT_MASK_BITS; // RQ26

	// ----------------------------------------
	// sequencer next state
	// ----------------------------------------
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		vec_d = vec_q;
		gie_d = wr_stat ? reg_wdata[`TFIRQ_BIT_GLOBAL_EN] : gie_q;
		case (st_q)
			tfirq_pkg::TFIRQ_RUN:
			begin
				if (start_entry)
				begin
					// entry drops the global enable
					st_d = tfirq_pkg::TFIRQ_ENTRY;
					cnt_d = `TFIRQ_ENTRY_CLKS; // RQ12
					vec_d = pick_vec;
					gie_d = 1'b0;
				end
				else if (handler_return_instruction)
				begin
					st_d = tfirq_pkg::TFIRQ_RETURN;
					cnt_d = `TFIRQ_RETURN_CLKS; // RQ14
				end
			end
			tfirq_pkg::TFIRQ_ENTRY:
			begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1)
				begin
					st_d = tfirq_pkg::TFIRQ_JUMP;
					cnt_d = `TFIRQ_JUMP_CLKS; // RQ12
				end
			end
			tfirq_pkg::TFIRQ_JUMP:
			begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1)
					st_d = tfirq_pkg::TFIRQ_RUN;
			end
			tfirq_pkg::TFIRQ_RETURN:
			begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1)
				begin
					st_d = tfirq_pkg::TFIRQ_AFTER;
					gie_d = 1'b1; // RQ14
				end
			end
			tfirq_pkg::TFIRQ_AFTER:
			begin
				// one main-program instruction first
				if (instr_done)
					st_d = tfirq_pkg::TFIRQ_RUN; // RQ15
			end
			default:
				st_d = tfirq_pkg::TFIRQ_RUN;
		endcase
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// unmapped addresses read zero
	always_comb
	begin
		if (reg_addr == `TFIRQ_OFS_TIMER_FLAGS)
			rdata_d = flags_q;
		else if (reg_addr == `TFIRQ_OFS_SLEEP_SENSE)
			rdata_d = ctl_q; // RQ9
		else if (reg_addr == `TFIRQ_OFS_TIMER_MASK)
			rdata_d = tmask_q;
		else if (reg_addr == `TFIRQ_OFS_EXT_MASK)
			rdata_d = emask_q;
		else if (reg_addr == `TFIRQ_OFS_EXT_FLAGS)
			rdata_d = eflag_q;
		else if (reg_addr == `TFIRQ_OFS_STATUS)
			rdata_d = {gie_q, 7'h00};
		else
			rdata_d = 8'h00;
	end

	// halt sleeps only when armed, depth selects the mode
	wire do_sleep = halt_instr & ctl_q[`TFIRQ_BIT_SLEEP_ARM]; // RQ16
	wire wake = any_req;

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_q <= `TFIRQ_RESET_VAL;
			eflag_q <= `TFIRQ_RESET_VAL;
			tmask_q <= `TFIRQ_RESET_VAL;
			emask_q <= `TFIRQ_RESET_VAL;
			ctl_q <= `TFIRQ_RESET_VAL;
			gie_q <= 1'b0;
			st_q <= tfirq_pkg::TFIRQ_RUN;
			cnt_q <= 3'h0;
			vec_q <= 3'h0;
		end
		else
		begin
			flags_q <= flags_d;
			eflag_q <= eflag_d;
			if (wr_tmask)
				tmask_q <= reg_wdata & `TFIRQ_TIMER_MASK_BITS; // RQ25
			if (wr_emask)
				emask_q <= reg_wdata & `TFIRQ_EXT_MASK_BITS; // RQ23
			if (wr_ctl)
				ctl_q <= reg_wdata & `TFIRQ_SLEEP_SENSE_BITS; // RQ9
			gie_q <= gie_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			vec_q <= vec_d;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 8'h00;
			irq_take <= 1'b0;
			irq_vector <= 3'h0;
			vector_jump <= 1'b0;
			sp_dec2 <= 1'b0;
			sp_inc2 <= 1'b0;
			sleep_idle <= 1'b0;
			sleep_power_down <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
			irq_take <= start_entry;
			irq_vector <= vec_d;
			vector_jump <= (st_d == tfirq_pkg::TFIRQ_JUMP);
			sp_dec2 <= start_entry; // RQ12
			sp_inc2 <= (st_q == tfirq_pkg::TFIRQ_RUN) & ~start_entry &
				handler_return_instruction; // RQ14
			// sleep held until any enabled request wakes the core
			if (wake)
			begin
				sleep_idle <= 1'b0;
				sleep_power_down <= 1'b0;
			end
			else if (do_sleep)
			begin
				sleep_idle <= ~ctl_q[`TFIRQ_BIT_SLEEP_DEPTH]; // RQ17
				sleep_power_down <= ctl_q[`TFIRQ_BIT_SLEEP_DEPTH]; // RQ17
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_wide_ovf_set: assert property (@(posedge ref_clk) // RQ1
		disable iff (!rst_n)
		(wide_ovf_evt & ~wide_pwm_mode) |=> flags_q[7])
		else $error("wide overflow flag missed");
	a_pwm_leave_set: assert property (@(posedge ref_clk) // RQ2
		disable iff (!rst_n)
		(wide_pwm_mode & wide_leave_zero_evt) |=> flags_q[7])
		else $error("pwm overflow flag missed");
	a_compare_set: assert property (@(posedge ref_clk) // RQ3
		disable iff (!rst_n)
		(wide_count == compare_value) |=> flags_q[6])
		else $error("compare flag missed");
	a_capture_set: assert property (@(posedge ref_clk) // RQ4
		disable iff (!rst_n) capture_evt |=> flags_q[3])
		else $error("capture flag missed");
	a_narrow_ovf_set: assert property (@(posedge ref_clk) // RQ5
		disable iff (!rst_n) narrow_ovf_evt |=> flags_q[1])
		else $error("narrow overflow flag missed");
	// the served narrow overflow vector (6) loses its flag unless a new event lands with it
	a_vec_flag_clear: assert property (@(posedge ref_clk) // RQ6
		disable iff (!rst_n)
		(vec_clear && vec_q == 3'h6 && !narrow_ovf_evt) |=> !flags_q[1])
		else $error("served flag not cleared");
	a_w1c_clear: assert property (@(posedge ref_clk) // RQ7
		disable iff (!rst_n)
		(wr_tflag & reg_wdata[1] & ~narrow_ovf_evt) |=> ~flags_q[1])
		else $error("write one did not clear");
	a_reserved_zero: assert property (@(posedge ref_clk) // RQ9
		disable iff (!rst_n)
		(flags_q & ~`TFIRQ_TIMER_MASK_BITS) == 8'h00 && ctl_q[7:6] == 2'h0)
		else $error("reserved bit set");
	a_take_gated: assert property (@(posedge ref_clk) // RQ8
		disable iff (!rst_n) start_entry |-> gie_q)
		else $error("interrupt taken while disabled");
	a_level_take: assert property (@(posedge ref_clk) // RQ11
		disable iff (!rst_n) (gie_q && emask_q[6] && level_req[0]
		&& st_q == tfirq_pkg::TFIRQ_RUN && instr_done) |=> irq_take)
		else $error("level request not served");
	a_level_no_flag: assert property (@(posedge ref_clk) // RQ24
		disable iff (!rst_n)
		(ext_sel[0] == 2'h0) |=> !$rose(eflag_q[6]))
		else $error("level mode set a flag");
	a_entry_jump: assert property (@(posedge ref_clk) // RQ12
		disable iff (!rst_n) start_entry |=> ##3
		st_q == tfirq_pkg::TFIRQ_ENTRY ##1 vector_jump[*2])
		else $error("entry timing wrong");
	a_ret_stack: assert property (@(posedge ref_clk) // RQ14
		disable iff (!rst_n) (st_q == tfirq_pkg::TFIRQ_RUN && !start_entry
		&& handler_return_instruction) |=> sp_inc2)
		else $error("return did not raise the stack");
	// enable is back once the fourth return clock has passed
	a_return_gie: assert property (@(posedge ref_clk) // RQ14
		disable iff (!rst_n) $rose(sp_inc2) |-> ##4 gie_q)
		else $error("return did not restore enable");
	a_after_hold: assert property (@(posedge ref_clk) // RQ15
		disable iff (!rst_n)
		(st_q == tfirq_pkg::TFIRQ_AFTER) |=> !irq_take)
		else $error("interrupt served before one instruction");
	a_sleep_armed: assert property (@(posedge ref_clk) // RQ16
		disable iff (!rst_n)
		$rose(sleep_idle | sleep_power_down) |-> $past(ctl_q[5]))
		else $error("sleep without arm bit");
	a_sleep_depth: assert property (@(posedge ref_clk) // RQ17
		disable iff (!rst_n) (do_sleep && !wake)
		|=> sleep_power_down == $past(ctl_q[4]))
		else $error("sleep depth wrong");
	c_timer_take: cover property (@(posedge ref_clk) disable iff (!rst_n)
		start_entry & (pick_vec == 3'h6));
	c_level_take: cover property (@(posedge ref_clk) disable iff (!rst_n)
		start_entry & level_req[0]);
	c_return: cover property (@(posedge ref_clk) disable iff (!rst_n)
		st_q == tfirq_pkg::TFIRQ_AFTER && instr_done);
	c_power_down: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(sleep_power_down));
endmodule // tfirq_ctrl

/* tfirq_ctrl_tb.sv */
/*
 * self-checking bench for tfirq_ctrl: registers, flags, pins, entry,
 * return and sleep. assumes the core stand-in in tfirq_core_model.
 */
module tfirq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst_n, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic wide_ovf_evt, wide_pwm_mode, wide_leave_zero_evt;
	logic capture_evt, narrow_ovf_evt;
	logic [15:0] wide_count, compare_value;
	logic [1:0] pins; // bit 0 pin a, bit 1 pin b
	logic instr_done, halt_instr, handler_return_instruction;
	logic irq_take, vector_jump, sp_dec2, sp_inc2, sleep_idle;
	logic sleep_power_down, done_prev;
	logic [2:0] irq_vector;
	logic run_en, slow, step_req, halt_req, ret_req;
	int errors, checks, takes;
	tfirq_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.wide_ovf_evt(wide_ovf_evt), .wide_pwm_mode(wide_pwm_mode),
		.wide_leave_zero_evt(wide_leave_zero_evt), .wide_count(wide_count),
		.compare_value(compare_value), .capture_evt(capture_evt),
		.narrow_ovf_evt(narrow_ovf_evt), .ext_irq_pin_a(pins[0]),
		.ext_irq_pin_b(pins[1]), .instr_done(instr_done),
		.halt_instr(halt_instr),
		.handler_return_instruction(handler_return_instruction),
		.irq_take(irq_take), .irq_vector(irq_vector),
		.vector_jump(vector_jump), .sp_dec2(sp_dec2), .sp_inc2(sp_inc2),
		.sleep_idle(sleep_idle), .sleep_power_down(sleep_power_down));
	tfirq_core_model core_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.run_en(run_en), .slow(slow), .step_req(step_req),
		.halt_req(halt_req), .ret_req(ret_req), .instr_done(instr_done),
		.halt_instr(halt_instr),
		.handler_return_instruction(handler_return_instruction));
	// ----------------------------------------
	// clock, watchers, watchdog
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// count vector takes and remember the previous boundary
	always @(posedge ref_clk)
	begin
		done_prev <= instr_done;
		if (irq_take === 1'b1)
			takes++;
	end
	// whole run is a few hundred clocks; this is far beyond it
	initial
	begin
		#500000;
		errors++;
		summarize();
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask
	// one-cycle timer events: wide ovf, leave zero, match, capture, narrow
	task automatic ev(input logic [4:0] m);
		@(posedge ref_clk);
		wide_ovf_evt <= m[4];
		wide_leave_zero_evt <= m[3];
		wide_count <= {15'h0000, m[2]};
		capture_evt <= m[1];
		narrow_ovf_evt <= m[0];
		@(posedge ref_clk);
		{wide_ovf_evt, wide_leave_zero_evt, capture_evt} <= 3'h0;
		narrow_ovf_evt <= 1'b0;
		wide_count <= 16'h0000;
	endtask
	// pulse one of the core requests for a cycle
	task automatic pulse(input logic [1:0] k);
		@(posedge ref_clk);
		{step_req, halt_req, ret_req} <= {k == 2'h0, k == 2'h1, k == 2'h2};
		@(posedge ref_clk);
		{step_req, halt_req, ret_req} <= 3'h0;
	endtask
	task automatic wait_take(input logic [2:0] v);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		while (irq_take !== 1'b1 && n < 40)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		cmp({7'h00, irq_take}, 8'h01);
		cmp({5'h00, irq_vector}, {5'h00, v});
		cmp({7'h00, sp_dec2}, 8'h01);
		cmp({7'h00, done_prev}, 8'h01);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_flags();
		reset();
		ev(5'h17);
		chk(8'h38, 8'hca);
		wr(8'h38, 8'h0a);
		chk(8'h38, 8'hc0);
		wr(8'h38, 8'hff);
		chk(8'h38, 8'h00);
		@(posedge ref_clk);
		wide_pwm_mode <= 1'b1;
		ev(5'h10);
		chk(8'h38, 8'h00);
		ev(5'h08);
		chk(8'h38, 8'h80);
		ev(5'h01);
		// clear and a new event in the same cycle: the event must survive
		@(posedge ref_clk);
		{reg_addr, reg_wdata, reg_wr} <= {8'h38, 8'h02, 1'b1};
		narrow_ovf_evt <= 1'b1;
		@(posedge ref_clk);
		{reg_wr, narrow_ovf_evt} <= 2'h0;
		chk(8'h38, 8'h82);
		wr(8'h35, 8'hff);
		chk(8'h35, 8'h3f);
		wr(8'h39, 8'hff);
		chk(8'h39, 8'hca);
		wr(8'h3b, 8'hff);
		chk(8'h3b, 8'hc0);
		chk(8'h00, 8'h00);
	endtask
	// pins driven as if the port were an output; mask stays off while
	// the sense bits change
	task automatic t_ext();
		logic [7:0] s, f;
		reset();
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < 4; c++)
			begin
				s = 8'(c) << (2 * p);
				f = p ? 8'h80 : 8'h40;
				wr(8'h35, s);
				chk(8'h35, s);
				wr(8'h3a, 8'hc0);
				pins[p] <= 1'b0;
				repeat (4) @(posedge ref_clk);
				chk(8'h3a, (c == 1 || c == 2) ? f : 8'h00);
				wr(8'h3a, 8'hc0);
				pins[p] <= 1'b1;
				repeat (4) @(posedge ref_clk);
				chk(8'h3a, (c == 1 || c == 3) ? f : 8'h00);
			end
	endtask
	task automatic t_sleep();
		for (int dp = 0; dp < 2; dp++)
		begin
			reset();
			wr(8'h35, dp ? 8'h10 : 8'h00);
			pulse(2'h1);
			repeat (3) @(posedge ref_clk);
			#1 cmp({6'h00, sleep_idle, sleep_power_down}, 8'h00);
			wr(8'h35, dp ? 8'h30 : 8'h20);
			pulse(2'h1);
			repeat (3) @(posedge ref_clk);
			#1 cmp({6'h00, sleep_idle, sleep_power_down}, dp ? 8'h01 : 8'h02);
		end
	endtask
	task automatic t_entry();
		reset();
		run_en <= 1'b1;
		wr(8'h39, 8'h02);
		ev(5'h01);
		repeat (6) @(posedge ref_clk);
		#1 cmp(takes[7:0], 8'h00);
		wr(8'h3f, 8'h80);
		wait_take(3'h6);
		repeat (4) @(posedge ref_clk);
		#1 cmp({7'h00, vector_jump}, 8'h01);
		@(posedge ref_clk);
		#1 cmp({7'h00, vector_jump}, 8'h01);
		@(posedge ref_clk);
		#1 cmp({7'h00, vector_jump}, 8'h00);
		chk(8'h38, 8'h00);
		run_en <= 1'b0;
		ev(5'h01);
		pulse(2'h2);
		@(posedge ref_clk);
		#1 cmp({7'h00, sp_inc2}, 8'h01);
		repeat (4) @(posedge ref_clk);
		chk(8'h3f, 8'h80);
		pulse(2'h0);
		repeat (6) @(posedge ref_clk);
		#1 cmp(takes[7:0], 8'h01);
		run_en <= 1'b1;
		wait_take(3'h6);
	endtask
	// low level held past the slow instruction boundary
	task automatic t_level();
		for (int p = 0; p < 2; p++)
		begin
			reset();
			{run_en, slow} <= 2'h3;
			wr(8'h3b, p ? 8'h80 : 8'h40);
			wr(8'h3f, 8'h80);
			pins[p] <= 1'b0;
			wait_take(p ? 3'h2 : 3'h1);
			chk(8'h3a, 8'h00);
			@(posedge ref_clk);
			pins[p] <= 1'b1;
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		errors = 0;
		checks = 0;
		takes = 0;
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h0;
		{wide_ovf_evt, wide_pwm_mode, wide_leave_zero_evt} = 3'h0;
		{capture_evt, narrow_ovf_evt, wide_count} = 18'h0;
		compare_value = 16'h0001;
		pins = 2'h3;
		{run_en, slow, step_req, halt_req, ret_req} = 5'h0;
		t_flags();
		t_ext();
		t_sleep();
		t_entry();
		t_level();
		summarize();
	end
endmodule // tfirq_ctrl_tb

/* tfirq_pkg.sv */
/*
 * types shared by the timer flag / external interrupt block.
 * assumes nothing beyond the constants header.
 */
package tfirq_pkg;
	// sequencer of the processor-facing interrupt handshake
	typedef enum logic [2:0] {
		TFIRQ_RUN = 3'b000,
		TFIRQ_ENTRY = 3'b001,
		TFIRQ_JUMP = 3'b010,
		TFIRQ_RETURN = 3'b011,
		TFIRQ_AFTER = 3'b100
	} tfirq_state_type;
	// sense-select encodings
	typedef enum logic [1:0] {
		TFIRQ_LOW = 2'b00,
		TFIRQ_ANY = 2'b01,
		TFIRQ_FALL = 2'b10,
		TFIRQ_RISE = 2'b11
	} tfirq_sense_type;
endpackage

/* tfirq_regs.svh */
/*
 * register offsets, field positions, reset values and timing counts for the
 * timer flag / external interrupt / sleep control block.
 * assumes a single 20 MHz clock and a plain strobe register port.
 */
// Behaviour
// RQ1 - wide overflow sets flag bit 7
// RQ2 - pulse-width mode: set on leaving zero
// RQ3 - compare match sets flag bit 6
// RQ4 - capture event sets flag bit 3
// RQ5 - narrow overflow sets flag bit 1
// RQ6 - vectoring clears the served timer flag
// RQ7 - writing one clears a timer flag
// RQ8 - take only with global, enable, flag
// RQ9 - reserved bits read as zero
// RQ10 - pins detect events even when outputs
// RQ11 - low level requests while pin low
// RQ12 - entry at least four clocks, jump two
// RQ13 - finish multi-cycle instruction before entry
// RQ14 - return takes four clocks, sets global
// RQ15 - one main instruction after return
// RQ16 - halt sleeps only with arm bit 5
// RQ17 - depth bit 4: idle or power-down
// RQ18 - second pin sense bits 3 and 2
// RQ19 - first pin sense bits 1 and 0
// RQ20 - software disables before changing sense
// RQ21 - pin sampled by clock before detection
// RQ22 - source holds low level until done
// RQ23 - ext mask bits 7 and 6
// RQ24 - low level sets no flag, still requests
// RQ25 - timer mask bit per source
// RQ26 - hardware set beats write-one clear
`ifndef TFIRQ_REGS_SVH
`define TFIRQ_REGS_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define TFIRQ_OFS_SLEEP_SENSE 8'h35
`define TFIRQ_OFS_TIMER_MASK 8'h39
`define TFIRQ_OFS_EXT_FLAGS 8'h3a
`define TFIRQ_OFS_EXT_MASK 8'h3b
`define TFIRQ_OFS_TIMER_FLAGS 8'h38
`define TFIRQ_OFS_STATUS 8'h3f
// ----------------------------------------
// fields
// ----------------------------------------
`define TFIRQ_BIT_WIDE_OVF 7
`define TFIRQ_BIT_COMPARE 6
`define TFIRQ_BIT_CAPTURE 3
`define TFIRQ_BIT_NARROW_OVF 1
`define TFIRQ_BIT_EXT_B 7
`define TFIRQ_BIT_EXT_A 6
`define TFIRQ_BIT_SLEEP_ARM 5
`define TFIRQ_BIT_SLEEP_DEPTH 4
`define TFIRQ_BIT_GLOBAL_EN 7
`define TFIRQ_TIMER_MASK_BITS 8'hca
`define TFIRQ_EXT_MASK_BITS 8'hc0
`define TFIRQ_SLEEP_SENSE_BITS 8'h3f
`define TFIRQ_RESET_VAL 8'h00
// ----------------------------------------
// timing in clocks
// ----------------------------------------
`define TFIRQ_ENTRY_CLKS 3'h4
`define TFIRQ_JUMP_CLKS 3'h2
`define TFIRQ_RETURN_CLKS 3'h4
`endif
